// file: core/cwd_cfg_mem.v
// Small non-volatile word store for the special configuration space
`timescale 1ns/100ps
`include "cwd_regs.vh"

module cwd_cfg_mem #(
  parameter                 AW       = 4,
  parameter                 DW       = 14,
  parameter [3:0]           CAL_IDX  = 4'h8,
  parameter [13:0]          CAL_INIT = `CWD_CAL_RESET
) (
  input  wire               clk,
  input  wire               nrst,
  input  wire               we,
  input  wire [AW-1:0]      waddr,
  input  wire [DW-1:0]      wdata,
  input  wire               erase,
  input  wire [AW-1:0]      raddr,
  output reg  [DW-1:0]      rdata_ff
);

  reg [DW-1:0] mem_ff [0:(1<<AW)-1];
  integer      i;
  integer      k;

  // Power-on image: every word blank except the factory calibration word
  initial begin
    for (k = 0; k < (1<<AW); k = k + 1) begin
      mem_ff[k] = (k == CAL_IDX) ? CAL_INIT : `CWD_ERASED;
    end
  end

  // Non-volatile: a device reset leaves the words alone so programmed
  // settings reach the next load; programming only clears bits, erase
  // returns every word but the calibration word to all ones
  always @(posedge clk) begin
    if (erase) begin
      for (i = 0; i < (1<<AW); i = i + 1) begin
        if (i != CAL_IDX) begin
          mem_ff[i] <= `CWD_ERASED; // see RULE_13
        end
      end
    end else if (we) begin
      mem_ff[waddr] <= mem_ff[waddr] & wdata; // see RULE_17
    end
  end

  // Registered read port
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= `CWD_ERASED;
    end else begin
      rdata_ff <= mem_ff[raddr];
    end
  end

endmodule

// file: core/cwd_config_word_decode.v
// Loads and decodes the configuration and calibration words at reset
`timescale 1ns/100ps
`include "cwd_regs.vh"

// Functional notes
// RULE_01: Bit 5 picks external reset or input.
// RULE_02: Bit 4 high disables power-up timer.
// RULE_03: Bit 3 forces watchdog, else software bit.
// RULE_04: Codes 111/110: RC, clock out or I/O.
// RULE_05: Codes 101/100: internal oscillator, pin roles.
// RULE_06: Code 011: outside clock in, pin freed.
// RULE_07: Codes 010/001/000: crystal HS, XT, LP.
// RULE_08: Droop detection never enables power-up timer.
// RULE_09: Data protection off erases data EEPROM.
// RULE_10: Program protection off erases program memory.
// RULE_11: Reset held in internal/RC mode stops oscillator.
// RULE_12: Oscillator, power-on, droop trims from calibration.
// RULE_13: Calibration word survives device erase.
// RULE_14: Space 2000h-3FFFh only in programming mode.
// RULE_15: Oscillator trim is signed seven-bit value.
// RULE_16: Power-on trim 2 bits; droop 000 reserved.
// RULE_17: Programmed bits read 0, blank read 1.
// RULE_18: Read words once at reset, then hold.
module cwd_config_word_decode #(
  parameter [13:0]          CAL_INIT = `CWD_CAL_RESET
) (
  input  wire               CLK_SYS,
  input  wire               NRST,
  input  wire               PROG_MODE,
  input  wire [13:0]        PROG_ADDR,
  input  wire [13:0]        PROG_WDATA,
  input  wire               PROG_WE,
  input  wire               PROG_RE,
  input  wire               PROG_BULK_ERASE,
  output reg  [13:0]        PROG_RDATA,
  output reg                PROG_RVALID,
  input  wire               EXTERNAL_RESET_INPUT_N,
  input  wire               SOFTWARE_WATCHDOG_ON,
  output reg                SETTINGS_VALID,
  output reg                PIN_RESET_ROLE_SELECT,
  output reg                PIN_RESET_ACTIVE,
  output reg                SHARED_INPUT_PIN,
  output reg                POWERUP_TIMER_ENABLE,
  output reg                WATCHDOG_ENABLE,
  output reg  [2:0]         OSCILLATOR_CHOICE,
  output reg                OSC_RC_SEL,
  output reg                OSC_INTERNAL_SEL,
  output reg                OSC_OUTSIDE_CLOCK_SEL,
  output reg                OSC_CRYSTAL_SEL,
  output reg  [1:0]         CRYSTAL_DRIVE,
  output reg                CLOCK_OUTPUT_FUNCTION,
  output reg                OSC1_IS_IO,
  output reg                OSC2_IS_IO,
  output reg                INT_OSC_STOP,
  output reg  [6:0]         OSCILLATOR_TRIM,
  output reg  [1:0]         POR_TRIM,
  output reg  [2:0]         SUPPLY_DROOP_TRIM,
  output reg                DROOP_TRIM_VALID,
  output reg                ERASE_DATA_MEM,
  output reg                ERASE_PROG_MEM
);

  // One-hot load sequencer states
  localparam [3:0] ST_CFG  = 4'h1;
  localparam [3:0] ST_CAL  = 4'h2;
  localparam [3:0] ST_LAST = 4'h4;
  localparam [3:0] ST_RUN  = 4'h8;

  // Word slots of the setup and trim words inside the small store
  localparam [13:0] OFS_SETUP = `CWD_SETUP_ADDR - `CWD_SPACE_BASE;
  localparam [13:0] OFS_TRIM  = `CWD_TRIM_ADDR - `CWD_SPACE_BASE;
  localparam [3:0]  IDX_SETUP = OFS_SETUP[3:0];
  localparam [3:0]  IDX_TRIM  = OFS_TRIM[3:0];

  reg  [3:0]  state_ff;
  reg  [3:0]  nxt_state;
  reg  [13:0] cfg_ff;
  reg  [1:0]  prot_ff;        // [1] data, [0] program protection off
  reg         rd_pend_ff;
  reg         rd_hit_ff;
  reg  [3:0]  mem_raddr;
  wire [13:0] mem_rdata;

  // True when the address lies in the mapped part of the special space
  function in_store;
    input [13:0] addr;
    begin
      in_store = (addr >= `CWD_SPACE_BASE) &&
                 (addr <= (`CWD_SPACE_BASE + 14'h000F));
    end
  endfunction

  // Requests count only once loading is over and programming mode is on;
  // a strobe during the load is dropped without an answer
  wire        in_space = (PROG_ADDR >= `CWD_SPACE_BASE); // see RULE_14
  wire        run      = state_ff[3];
  wire        acc_ok   = run & PROG_MODE & in_space;     // see RULE_14
  wire [3:0]  acc_idx  = PROG_ADDR[3:0];
  wire        acc_hit  = acc_ok & in_store(PROG_ADDR);
  wire        do_erase = acc_ok & PROG_BULK_ERASE;
  wire        do_write = acc_hit & PROG_WE & ~PROG_BULK_ERASE;
  wire        do_read  = acc_ok & PROG_RE;

  // Reserved bits are forced as stored: setup 13:12 blank, trim 13 and 5 zero
  reg  [13:0] wr_word;
  always @* begin
    wr_word = PROG_WDATA;
    if (acc_idx == IDX_SETUP) begin
      wr_word = PROG_WDATA | `CWD_CFG_FORCE_ONE;
    end else if (acc_idx == IDX_TRIM) begin
      wr_word = PROG_WDATA & `CWD_CAL_KEEP_MASK;
    end
  end

  cwd_cfg_mem #(
    .AW       (4),
    .DW       (14),
    .CAL_IDX  (IDX_TRIM),
    .CAL_INIT (CAL_INIT)
  ) u_mem (
    .clk      (CLK_SYS),
    .nrst     (NRST),
    .we       (do_write),
    .waddr    (acc_idx),
    .wdata    (wr_word),
    .erase    (do_erase),
    .raddr    (mem_raddr),
    .rdata_ff (mem_rdata)
  );

  // Read address and next state of the load sequencer
  always @* begin
    mem_raddr = acc_idx;
    nxt_state = state_ff;
    case (state_ff)
      ST_CFG: begin
        mem_raddr = IDX_SETUP;
        nxt_state = ST_CAL;
      end
      ST_CAL: begin
        mem_raddr = IDX_TRIM;
        nxt_state = ST_LAST;
      end
      ST_LAST: begin
        nxt_state = ST_RUN;
      end
      ST_RUN: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_CFG;
      end
    endcase
  end

  // Sequencer; words are fetched once after reset and then held
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      state_ff <= ST_CFG;
      cfg_ff   <= `CWD_ERASED;
    end else begin
      state_ff <= nxt_state; // see RULE_18
      if (state_ff == ST_CAL) begin
        cfg_ff <= mem_rdata; // see RULE_18
      end
    end
  end

  // Decoded settings, latched as the calibration word arrives
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      SETTINGS_VALID        <= 1'b0;
      PIN_RESET_ROLE_SELECT <= 1'b1;
      POWERUP_TIMER_ENABLE  <= 1'b0;
      OSCILLATOR_CHOICE     <= `CWD_OSC_RC_CLOCK_OUTPUT_FUNCTION;
      OSC_RC_SEL            <= 1'b0;
      OSC_INTERNAL_SEL      <= 1'b0;
      OSC_OUTSIDE_CLOCK_SEL <= 1'b0;
      OSC_CRYSTAL_SEL       <= 1'b0;
      CRYSTAL_DRIVE         <= 2'h0;
      CLOCK_OUTPUT_FUNCTION <= 1'b0;
      OSC1_IS_IO            <= 1'b0;
      OSC2_IS_IO            <= 1'b0;
      OSCILLATOR_TRIM       <= 7'h00;
      POR_TRIM              <= 2'h0;
      SUPPLY_DROOP_TRIM     <= 3'h0;
      DROOP_TRIM_VALID      <= 1'b0;
    end else if (state_ff == ST_LAST) begin
      SETTINGS_VALID        <= 1'b1;
      PIN_RESET_ROLE_SELECT <= cfg_ff[`CWD_CFG_ROLE_BIT]; // see RULE_01
      // Timer follows only its own bit; droop settings never enable it
      POWERUP_TIMER_ENABLE  <=
        ~cfg_ff[`CWD_CFG_POWERUP_TIMER_BIT]; // see RULE_02 RULE_08
      OSCILLATOR_CHOICE     <= cfg_ff[`CWD_CFG_OSC_HI:`CWD_CFG_OSC_LO];
      OSC_RC_SEL            <= 1'b0;
      OSC_INTERNAL_SEL      <= 1'b0;
      OSC_OUTSIDE_CLOCK_SEL <= 1'b0;
      OSC_CRYSTAL_SEL       <= 1'b0;
      CRYSTAL_DRIVE         <= 2'h0;
      CLOCK_OUTPUT_FUNCTION <= 1'b0;
      OSC1_IS_IO            <= 1'b0;
      OSC2_IS_IO            <= 1'b0;
      case (cfg_ff[`CWD_CFG_OSC_HI:`CWD_CFG_OSC_LO])
        `CWD_OSC_RC_CLOCK_OUTPUT_FUNCTION: begin
          OSC_RC_SEL            <= 1'b1; // see RULE_04
          CLOCK_OUTPUT_FUNCTION <= 1'b1;
        end
        `CWD_OSC_RC_IO: begin
          OSC_RC_SEL <= 1'b1; // see RULE_04
          OSC2_IS_IO <= 1'b1;
        end
        `CWD_OSC_INT_CLOCK_OUTPUT_FUNCTION: begin
          OSC_INTERNAL_SEL      <= 1'b1; // see RULE_05
          CLOCK_OUTPUT_FUNCTION <= 1'b1;
          OSC1_IS_IO            <= 1'b1;
        end
        `CWD_OSC_INT_IO: begin
          OSC_INTERNAL_SEL <= 1'b1; // see RULE_05
          OSC1_IS_IO       <= 1'b1;
          OSC2_IS_IO       <= 1'b1;
        end
        `CWD_OSC_EXT_CLK: begin
          OSC_OUTSIDE_CLOCK_SEL <= 1'b1; // see RULE_06
          OSC2_IS_IO            <= 1'b1;
        end
        default: begin
          OSC_CRYSTAL_SEL <= 1'b1; // see RULE_07
          CRYSTAL_DRIVE   <= cfg_ff[1:0];
        end
      endcase
      // Factory trims pass through unchanged; oscillator trim stays signed
      OSCILLATOR_TRIM   <=
        mem_rdata[`CWD_CAL_OSC_HI:`CWD_CAL_OSC_LO]; // see RULE_12 RULE_15
      POR_TRIM          <=
        mem_rdata[`CWD_CAL_POR_HI:`CWD_CAL_POR_LO]; // see RULE_12
      SUPPLY_DROOP_TRIM <=
        mem_rdata[`CWD_CAL_DROOP_HI:`CWD_CAL_DROOP_LO]; // see RULE_12
      DROOP_TRIM_VALID  <= mem_rdata[`CWD_CAL_DROOP_HI:`CWD_CAL_DROOP_LO]
                           != `CWD_DROOP_RSVD; // see RULE_16
    end
  end

  // Live pin, watchdog and oscillator-stop outputs
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      PIN_RESET_ACTIVE <= 1'b0;
      SHARED_INPUT_PIN <= 1'b0;
      WATCHDOG_ENABLE  <= 1'b0;
      INT_OSC_STOP     <= 1'b0;
    end else begin
      // Reset role held inactive when the pin is a plain input
      PIN_RESET_ACTIVE <= SETTINGS_VALID & PIN_RESET_ROLE_SELECT &
                          ~EXTERNAL_RESET_INPUT_N; // see RULE_01
      SHARED_INPUT_PIN <= ~PIN_RESET_ROLE_SELECT &
                          EXTERNAL_RESET_INPUT_N; // see RULE_01
      WATCHDOG_ENABLE  <= SETTINGS_VALID &
                          (cfg_ff[`CWD_CFG_WDT_BIT] |
                           SOFTWARE_WATCHDOG_ON); // see RULE_03
      INT_OSC_STOP     <= SETTINGS_VALID & PIN_RESET_ROLE_SELECT &
                          ~EXTERNAL_RESET_INPUT_N &
                          (OSC_RC_SEL | OSC_INTERNAL_SEL); // see RULE_11
    end
  end

  // Protection tracking; erase with protection on lifts it and wipes memory
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      prot_ff        <= 2'h3;
      ERASE_DATA_MEM <= 1'b0;
      ERASE_PROG_MEM <= 1'b0;
    end else begin
      ERASE_DATA_MEM <= do_erase & ~prot_ff[1]; // see RULE_09
      ERASE_PROG_MEM <= do_erase & ~prot_ff[0]; // see RULE_10
      // Writes only clear bits, so a write can switch protection on only
      if (state_ff == ST_CAL) begin
        prot_ff <= {mem_rdata[`CWD_CFG_CPD_BIT], mem_rdata[`CWD_CFG_CP_BIT]};
      end else if (do_erase) begin
        prot_ff <= 2'h3;
      end else if (do_write && acc_idx == IDX_SETUP) begin
        prot_ff <= prot_ff & {PROG_WDATA[`CWD_CFG_CPD_BIT],
                              PROG_WDATA[`CWD_CFG_CP_BIT]};
      end
    end
  end

  // Programmer read answer, two cycles after the request
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rd_pend_ff  <= 1'b0;
      rd_hit_ff   <= 1'b0;
      PROG_RDATA  <= 14'h0000;
      PROG_RVALID <= 1'b0;
    end else begin
      rd_pend_ff  <= do_read;
      rd_hit_ff   <= acc_hit;
      PROG_RVALID <= rd_pend_ff; // see RULE_14
      if (rd_pend_ff) begin
        PROG_RDATA <= rd_hit_ff ? mem_rdata : `CWD_ERASED; // see RULE_17
      end
    end
  end

endmodule

// file: core/cwd_regs.vh
// Address map, field positions, reset values and codes of the config decoder
`ifndef CWD_REGS_VH
`define CWD_REGS_VH

// Special configuration space, reachable only in programming mode
`define CWD_SPACE_BASE      14'h2000
`define CWD_SPACE_LAST      14'h3FFF
`define CWD_SETUP_ADDR      14'h2007
`define CWD_TRIM_ADDR       14'h2008

// Word width and erased (unprogrammed) value
`define CWD_WORD_W          14
`define CWD_ERASED          14'h3FFF

// device_setup_word fields
`define CWD_CFG_CPD_BIT     7
`define CWD_CFG_CP_BIT      6
`define CWD_CFG_ROLE_BIT    5
`define CWD_CFG_POWERUP_TIMER_BIT    4
`define CWD_CFG_WDT_BIT     3
`define CWD_CFG_OSC_HI      2
`define CWD_CFG_OSC_LO      0
`define CWD_CFG_FORCE_ONE   14'h3000

// factory_trim_word fields
`define CWD_CAL_OSC_HI      12
`define CWD_CAL_OSC_LO      6
`define CWD_CAL_POR_HI      4
`define CWD_CAL_POR_LO      3
`define CWD_CAL_DROOP_HI    2
`define CWD_CAL_DROOP_LO    0
`define CWD_CAL_KEEP_MASK   14'h1FDF
`define CWD_CAL_RESET       14'h0012

// oscillator_choice codes
`define CWD_OSC_RC_CLOCK_OUTPUT_FUNCTION   3'h7
`define CWD_OSC_RC_IO       3'h6
`define CWD_OSC_INT_CLOCK_OUTPUT_FUNCTION  3'h5
`define CWD_OSC_INT_IO      3'h4
`define CWD_OSC_EXT_CLK     3'h3
`define CWD_OSC_XTAL_HS     3'h2
`define CWD_OSC_XTAL_XT     3'h1
`define CWD_OSC_XTAL_LP     3'h0

// Reserved droop trim code
`define CWD_DROOP_RSVD      3'h0

`endif

// file: dv/cwd_checker_props.sv
// Port-level assertions for the configuration word decoder
`timescale 1ns/100ps
module cwd_checker (
  input wire        CLK_SYS,
  input wire        NRST,
  input wire        PROG_MODE,
  input wire [13:0] PROG_ADDR,
  input wire        PROG_RE,
  input wire        PROG_BULK_ERASE,
  input wire        PROG_RVALID,
  input wire        EXTERNAL_RESET_INPUT_N,
  input wire        SOFTWARE_WATCHDOG_ON,
  input wire        SETTINGS_VALID,
  input wire        PIN_RESET_ROLE_SELECT,
  input wire        PIN_RESET_ACTIVE,
  input wire        WATCHDOG_ENABLE,
  input wire [2:0]  OSCILLATOR_CHOICE,
  input wire        OSC_RC_SEL,
  input wire        OSC_INTERNAL_SEL,
  input wire        OSC_CRYSTAL_SEL,
  input wire [1:0]  CRYSTAL_DRIVE,
  input wire        CLOCK_OUTPUT_FUNCTION,
  input wire        OSC1_IS_IO,
  input wire        OSC2_IS_IO,
  input wire        INT_OSC_STOP,
  input wire [6:0]  OSCILLATOR_TRIM,
  input wire [2:0]  SUPPLY_DROOP_TRIM,
  input wire        DROOP_TRIM_VALID,
  input wire        ERASE_PROG_MEM
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // Short names for loaded state and accepted requests
  wire       sv = SETTINGS_VALID;
  wire [2:0] oc = OSCILLATOR_CHOICE;
  wire       rq = PROG_RE && PROG_MODE && PROG_ADDR >= 14'h2000;
  wire       er = PROG_BULK_ERASE && PROG_MODE;

  read_answer_a: assert property (sv && rq |-> ##2 PROG_RVALID)
    else $error("accepted read got no answer");
  answer_cause_a: assert property (PROG_RVALID |-> $past(rq, 2))
    else $error("answer without an accepted read");
  role_reset_a: assert property (sv && PIN_RESET_ROLE_SELECT
    && !EXTERNAL_RESET_INPUT_N |=> PIN_RESET_ACTIVE)
    else $error("pin reset not active");
  watchdog_on_a: assert property (sv && SOFTWARE_WATCHDOG_ON
    |=> WATCHDOG_ENABLE) else $error("software watchdog ignored");
  rc_decode_a: assert property (sv |-> OSC_RC_SEL == (oc >= 3'h6)
    && CLOCK_OUTPUT_FUNCTION == (oc[2] && oc[0])) else $error("rc decode");
  int_decode_a: assert property (sv |-> OSC_INTERNAL_SEL ==
    (oc[2:1] == 2'h2) && OSC1_IS_IO == (oc[2:1] == 2'h2))
    else $error("internal decode");
  pin_io_a: assert property (sv |-> OSC2_IS_IO ==
    (oc == 3'h6 || oc == 3'h4 || oc == 3'h3)) else $error("pin io decode");
  xtal_drive_a: assert property (sv |-> OSC_CRYSTAL_SEL == (oc < 3'h3)
    && CRYSTAL_DRIVE == (oc < 3'h3 ? oc[1:0] : 2'h0)) else $error("crystal");
  osc_stop_a: assert property (INT_OSC_STOP |-> PIN_RESET_ROLE_SELECT
    && (OSC_RC_SEL || OSC_INTERNAL_SEL)) else $error("bad oscillator stop");
  droop_valid_a: assert property (sv |-> DROOP_TRIM_VALID ==
    (SUPPLY_DROOP_TRIM != 3'h0)) else $error("droop trim flag");
  settings_hold_a: assert property (sv && $past(sv) |-> $stable(oc)
    && $stable(OSCILLATOR_TRIM)) else $error("settings changed");
  erase_pulse_a: assert property (ERASE_PROG_MEM |-> $past(er)
    ##1 !ERASE_PROG_MEM) else $error("bad erase pulse");
  // Main scenarios
  cover property (sv && rq);
  cover property (ERASE_PROG_MEM);
  cover property (INT_OSC_STOP);
  cover property (sv && OSC_CRYSTAL_SEL);
endmodule

// file: dv/cwd_prog_model.sv
// Programmer model driving the special configuration space port
`timescale 1ns/100ps
module cwd_prog_model (
  input  wire        clk,
  input  wire [13:0] rdata,
  input  wire        rvalid,
  output reg         mode,
  output reg  [13:0] addr,
  output reg  [13:0] wdata,
  output reg         we,
  output reg         re,
  output reg         erase
);
  // Access only in programming mode, which starts off
  initial {mode, addr, wdata, we, re, erase} = 44'h0;
  // One strobe cycle {we, re, erase}; strobes then drop to zero, address and data show the inverse
  // Bulk erase leaves the trim word untouched
  task pulse(input [2:0] s, input [13:0] a, input [13:0] d);
    begin
      @(posedge clk);
      {we, re, erase} <= s;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      {we, re, erase} <= 3'h0;
      addr <= ~a;
      wdata <= ~d;
    end
  endtask
  // Read; data is taken at the edge where the valid pulse is seen
  task rd(input [13:0] a, output [13:0] d, output ok);
    integer i;
    begin
      ok = 1'b0;
      d = 14'h0;
      pulse(3'h2, a, 14'h0);
      for (i = 0; i < 4 && !ok; i = i + 1) begin
        @(posedge clk);
        ok = (rvalid === 1'b1);
        d = rdata;
      end
    end
  endtask
endmodule

// file: dv/test_config_word_decode.sv
// Self-checking bench for the configuration word decoder
`timescale 1ns/100ps
module test_config_word_decode;
  localparam [13:0] CAL = 14'h101A;
  reg         clk_sys = 1'b0;
  reg         nrst = 1'b0;
  reg         pin_n = 1'b1;
  reg         sw_wdt = 1'b0;
  integer     n_fail = 0;
  integer     checks = 0;
  wire [13:0] p_a, p_wd, p_rd;
  wire        p_mode, p_we, p_re, p_er, p_rv;
  wire        sv, role, act, shp, powerup_timer, wdt, rc, isel, ocs, xs;
  wire        cko, io1, io2, stop, dv, ed, ep;
  wire [2:0]  oc, dt;
  wire [1:0]  cd, pt;
  wire [6:0]  ot;

  always #10 clk_sys = ~clk_sys;

  cwd_prog_model cwd_prog_model_i (.clk(clk_sys), .rdata(p_rd),
    .rvalid(p_rv), .mode(p_mode), .addr(p_a), .wdata(p_wd), .we(p_we),
    .re(p_re), .erase(p_er));
  cwd_config_word_decode #(.CAL_INIT(CAL)) cwd_config_word_decode_i (
    .CLK_SYS(clk_sys), .NRST(nrst), .PROG_MODE(p_mode), .PROG_ADDR(p_a),
    .PROG_WDATA(p_wd), .PROG_WE(p_we), .PROG_RE(p_re),
    .PROG_BULK_ERASE(p_er), .PROG_RDATA(p_rd), .PROG_RVALID(p_rv),
    .EXTERNAL_RESET_INPUT_N(pin_n), .SOFTWARE_WATCHDOG_ON(sw_wdt),
    .SETTINGS_VALID(sv), .PIN_RESET_ROLE_SELECT(role),
    .PIN_RESET_ACTIVE(act), .SHARED_INPUT_PIN(shp),
    .POWERUP_TIMER_ENABLE(powerup_timer), .WATCHDOG_ENABLE(wdt),
    .OSCILLATOR_CHOICE(oc), .OSC_RC_SEL(rc), .OSC_INTERNAL_SEL(isel),
    .OSC_OUTSIDE_CLOCK_SEL(ocs), .OSC_CRYSTAL_SEL(xs), .CRYSTAL_DRIVE(cd),
    .CLOCK_OUTPUT_FUNCTION(cko), .OSC1_IS_IO(io1), .OSC2_IS_IO(io2),
    .INT_OSC_STOP(stop), .OSCILLATOR_TRIM(ot), .POR_TRIM(pt),
    .SUPPLY_DROOP_TRIM(dt), .DROOP_TRIM_VALID(dv),
    .ERASE_DATA_MEM(ed), .ERASE_PROG_MEM(ep));

  // Verdict and end of run
  task end_sim;
    begin
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // Compare seen against expected
  task chk(input [13:0] seen, input [13:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // Read one word; eok says whether an answer is due
  task rdc(input [13:0] a, input [13:0] e, input eok);
    reg [13:0] d;
    reg        ok;
    begin
      cwd_prog_model_i.rd(a, d, ok);
      chk(ok, eok);
      if (eok)
        chk(d, e);
    end
  endtask
  // Reset for four cycles, then wait a bounded time for the load
  task do_reset;
    integer i;
    begin
      nrst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      for (i = 0; i < 10 && sv !== 1'b1; i = i + 1)
        @(posedge clk_sys);
      if (i == 10) begin
        n_fail = n_fail + 1;
        end_sim;
      end
      @(posedge clk_sys);
    end
  endtask

  // Main sequence
  initial begin
    do_reset;
    chk({role, shp}, 2'h2);
    chk(powerup_timer, 1'b0);
    chk(wdt, 1'b1);
    chk({oc, rc, isel, ocs, xs, cko, io1, io2}, 10'h3C4);
    chk(cd, 2'h0);
    chk({ot, pt, dt, dv}, {7'h40, 2'h3, 3'h2, 1'b1});
    pin_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({act, stop, shp}, 3'h6);
    pin_n <= 1'b1;
    sw_wdt <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({act, stop, wdt}, 3'h1);
    rdc(14'h2007, 14'h0, 1'b0);
    @(posedge clk_sys) cwd_prog_model_i.mode <= 1'b1;
    rdc(14'h1FFF, 14'h0, 1'b0);
    rdc(14'h2007, 14'h3FFF, 1'b1);
    rdc(14'h2008, CAL, 1'b1);
    cwd_prog_model_i.pulse(3'h4, 14'h2010, 14'h0);
    rdc(14'h2010, 14'h3FFF, 1'b1);
    cwd_prog_model_i.pulse(3'h4, 14'h2007, 14'h0F35);
    cwd_prog_model_i.pulse(3'h4, 14'h2007, 14'h3FFF);
    rdc(14'h2007, 14'h3F35, 1'b1);
    chk({oc, role}, 4'hF);
    cwd_prog_model_i.pulse(3'h4, 14'h2008, 14'h0FFF);
    cwd_prog_model_i.pulse(3'h1, 14'h2000, 14'h0);
    @(posedge clk_sys);
    chk({ed, ep}, 2'h3);
    rdc(14'h2007, 14'h3FFF, 1'b1);
    rdc(14'h2008, 14'h001A, 1'b1);
    cwd_prog_model_i.pulse(3'h1, 14'h2000, 14'h0);
    @(posedge clk_sys);
    chk({ed, ep}, 2'h0);
    // Program pin input, timer on, watchdog by software, fast crystal
    cwd_prog_model_i.pulse(3'h4, 14'h2007, 14'h3FC2);
    sw_wdt <= 1'b0;
    do_reset;
    rdc(14'h2008, 14'h001A, 1'b1);
    chk({oc, role, powerup_timer, wdt}, 6'h12);
    chk({rc, isel, ocs, xs, cko, io1, io2, cd}, 9'h022);
    chk({ot, pt, dt}, {7'h00, 2'h3, 3'h2});
    pin_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({act, stop, shp}, 3'h0);
    pin_n <= 1'b1;
    sw_wdt <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk({act, stop, shp, wdt}, 4'h3);
    end_sim;
  end
endmodule

bind cwd_config_word_decode cwd_checker cwd_checker_i (.*);
